/* File: rtl/sag_pkg.sv */
// Constants, encodings and state types shared by the address generator files.
package sag_pkg;

  // Data path widths.
  localparam int SAG_WORD_W = 16;
  localparam int SAG_PHYS_W = 20;
  localparam int SAG_SEG_SHIFT = 4;
  localparam int SAG_NUM_REGS = 14;

  // Register file slots; general registers use their instruction encoding order.
  localparam logic [3:0] SAG_IDX_ACCUMULATOR = 4'h0;
  localparam logic [3:0] SAG_IDX_COUNT = 4'h1;
  localparam logic [3:0] SAG_IDX_DATA = 4'h2;
  localparam logic [3:0] SAG_IDX_BASE = 4'h3;
  localparam logic [3:0] SAG_IDX_STACK_POINTER = 4'h4;
  localparam logic [3:0] SAG_IDX_BASE_POINTER = 4'h5;
  localparam logic [3:0] SAG_IDX_SOURCE_INDEX = 4'h6;
  localparam logic [3:0] SAG_IDX_DEST_INDEX = 4'h7;
  localparam logic [3:0] SAG_IDX_EXTRA_SEGMENT = 4'h8;
  localparam logic [3:0] SAG_IDX_CODE_SEGMENT = 4'h9;
  localparam logic [3:0] SAG_IDX_STACK_SEGMENT = 4'ha;
  localparam logic [3:0] SAG_IDX_DATA_SEGMENT = 4'hb;
  localparam logic [3:0] SAG_IDX_INSTRUCTION_POINTER = 4'hc;
  localparam logic [3:0] SAG_IDX_FLAGS = 4'hd;
  localparam logic [3:0] SAG_IDX_SEG_BASE = 4'h8;

  // Byte register codes: bit 2 picks the high half, bits 1:0 the word register.
  localparam int SAG_BYTE_HI_BIT = 2;

  // Reset value of every register in the core set.
  localparam logic [15:0] SAG_REG_RESET = 16'h0000;

  // Segment selector codes, in the order of the segment slots.
  typedef enum logic [1:0] {
    SAG_SEG_EXTRA = 2'b00,
    SAG_SEG_CODE = 2'b01,
    SAG_SEG_STACK = 2'b10,
    SAG_SEG_DATA = 2'b11
  } sag_seg_t;

  // Operand addressing modes: two non-memory modes and six memory modes.
  typedef enum logic [2:0] {
    SAG_MODE_REGISTER = 3'b000,
    SAG_MODE_IMMEDIATE = 3'b001,
    SAG_MODE_DIRECT = 3'b010,
    SAG_MODE_REG_INDIRECT = 3'b011,
    SAG_MODE_BASED = 3'b100,
    SAG_MODE_INDEXED = 3'b101,
    SAG_MODE_BASED_INDEXED = 3'b110,
    SAG_MODE_BASED_INDEXED_DISP = 3'b111
  } sag_mode_t;

  // State of the register file.
  typedef struct packed {
    logic [SAG_NUM_REGS-1:0][SAG_WORD_W-1:0] regs;
  } sag_rf_state_t;

  // State of the address generator output stage.
  typedef struct packed {
    logic [SAG_WORD_W-1:0] eff_addr;
    logic [SAG_PHYS_W-1:0] phys_addr;
    logic [SAG_PHYS_W-1:0] fetch_addr;
    logic [1:0] seg_sel;
    logic valid;
    logic mem_access;
    logic [SAG_WORD_W-1:0] operand;
  } sag_ag_state_t;

endpackage

/* File: rtl/sag_regfile.sv */
// Core register set: general, pointer, index, segment, instruction pointer, flags.
`timescale 1ns/1ps
`default_nettype none

module sag_regfile
  import sag_pkg::*;
(
  // Clock and reset.
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // Write port.
  input wire logic wr_en_in,
  input wire logic [3:0] wr_idx_in,
  input wire logic wr_byte_in,
  input wire logic [15:0] wr_data_in,
  // Whole register set, straight from the flops.
  output logic [SAG_NUM_REGS-1:0][SAG_WORD_W-1:0] regs_out
);

  // Present and next state of the register set.
  sag_rf_state_t state_reg;
  sag_rf_state_t state_next;

  // Write decode: word writes take any slot, byte writes only the four split registers.
  always_comb
  begin
    state_next = state_reg;
    if (wr_en_in)
    begin
      if (wr_byte_in)
      begin
        // Byte write into one half; the other half keeps its value.
        if (wr_idx_in[3] == 1'b0)
        begin
          if (wr_idx_in[SAG_BYTE_HI_BIT])
          begin
            state_next.regs[wr_idx_in[1:0]][15:8] = wr_data_in[7:0]; // RULE_11 RULE_12
          end
          else
          begin
            state_next.regs[wr_idx_in[1:0]][7:0] = wr_data_in[7:0]; // RULE_11 RULE_12
          end
        end
      end
      else if (wr_idx_in < 4'(SAG_NUM_REGS))
      begin
        // Full word write; codes above the flags slot are ignored.
        state_next.regs[wr_idx_in] = wr_data_in; // RULE_10 RULE_12
      end
    end
  end

  // Register the state; synchronous reset clears every register.
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      state_reg.regs <= {SAG_NUM_REGS{SAG_REG_RESET}};
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // The register set is visible to the address path at all times.
  assign regs_out = state_reg.regs;

endmodule

`default_nettype wire

/* File: rtl/sag_addr_gen.sv */
// Operand address generator with its core register set.
// Summary of operation
// (RULE_01) Physical address is segment shifted four plus offset.
// (RULE_02) Offset is 16 bits, segment spans 64K.
// (RULE_03) Offset sums displacement, base and index.
// (RULE_04) Offset sum drops carry beyond bit 15.
// (RULE_05) Byte displacement is sign extended to word.
// (RULE_06) Displacement is 8 or 16 bits.
// (RULE_07) Base from base registers, index from index registers.
// (RULE_08) Six memory addressing modes are provided.
// (RULE_09) Segment implied by mode unless overridden.
// (RULE_10) Fourteen 16-bit core registers are held.
// (RULE_11) Four registers split into two byte halves.
// (RULE_12) Register operands read or written as byte/word.
// (RULE_13) Immediate operand comes from instruction, no memory.
// (RULE_14) Direct mode offset equals the displacement.
// (RULE_15) Full mode sums base, index and displacement.
// (RULE_16) Physical address wraps within 1 Mbyte.
`timescale 1ns/1ps
`default_nettype none

module sag_addr_gen
  import sag_pkg::*;
(
  // Clock and reset.
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // Address request from the execution unit.
  input wire logic req_valid_in,
  input wire logic [2:0] mode_in,
  input wire logic base_sel_in,
  input wire logic index_sel_in,
  input wire logic ind_base_in,
  input wire logic [15:0] disp_in,
  input wire logic disp_wide_in,
  input wire logic seg_override_in,
  input wire logic [1:0] seg_override_sel_in,
  // Register operand selection for register mode.
  input wire logic [3:0] rd_idx_in,
  input wire logic rd_byte_in,
  // Register write port.
  input wire logic wr_en_in,
  input wire logic [3:0] wr_idx_in,
  input wire logic wr_byte_in,
  input wire logic [15:0] wr_data_in,
  // Results toward the bus interface unit and execution unit.
  output logic addr_valid_out,
  output logic mem_access_out,
  output logic [15:0] eff_addr_out,
  output logic [19:0] phys_addr_out,
  output logic [1:0] seg_sel_out,
  output logic [15:0] operand_out,
  output logic [19:0] fetch_addr_out
);

  // Register set as held by the register file.
  logic [SAG_NUM_REGS-1:0][SAG_WORD_W-1:0] regs;

  // Output stage state.
  sag_ag_state_t state_reg;
  sag_ag_state_t state_next;

  // Working values of the address calculation.
  sag_mode_t mode;
  logic [15:0] base_val;
  logic [15:0] index_val;
  logic [15:0] disp_val;
  logic [15:0] ea_val;
  logic [15:0] seg_val;
  logic [1:0] seg_sel;
  logic base_pointer_used;
  logic [2:0] elems;

  // Core register set.
  sag_regfile u_regfile (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .wr_en_in(wr_en_in),
    .wr_idx_in(wr_idx_in),
    .wr_byte_in(wr_byte_in),
    .wr_data_in(wr_data_in),
    .regs_out(regs)
  );

  // Elements used by a mode, as {displacement, base, index}.
  function automatic logic [2:0] mode_elems(input sag_mode_t m, input logic ind_base);
    logic [2:0] e;
    e = 3'b000;
    unique case (m)
      SAG_MODE_REGISTER: e = 3'b000;
      SAG_MODE_IMMEDIATE: e = 3'b000;
      SAG_MODE_DIRECT: e = 3'b100;
      SAG_MODE_REG_INDIRECT: e = ind_base ? 3'b010 : 3'b001;
      SAG_MODE_BASED: e = 3'b110;
      SAG_MODE_INDEXED: e = 3'b101;
      SAG_MODE_BASED_INDEXED: e = 3'b011;
      SAG_MODE_BASED_INDEXED_DISP: e = 3'b111;
    endcase
    return e; // RULE_08
  endfunction

  // Register operand read: byte codes pick a half of the four split registers.
  function automatic logic [15:0] read_operand(
    input logic [SAG_NUM_REGS-1:0][SAG_WORD_W-1:0] r,
    input logic [3:0] idx,
    input logic byte_sel
  );
    logic [15:0] w;
    w = 16'h0000;
    if (byte_sel)
    begin
      // Byte operands sit in the low half with the upper half zero.
      w = r[idx[1:0]];
      w = idx[SAG_BYTE_HI_BIT] ? {8'h00, w[15:8]} : {8'h00, w[7:0]}; // RULE_11
    end
    else if (idx < 4'(SAG_NUM_REGS))
    begin
      w = r[idx];
    end
    return w; // RULE_12
  endfunction

  // Select the elements and sum them into the effective address.
  always_comb
  begin
    mode = sag_mode_t'(mode_in);
    elems = mode_elems(mode, ind_base_in);
    // Base element from the base register or the base pointer.
    base_val = base_sel_in ? regs[SAG_IDX_BASE_POINTER] : regs[SAG_IDX_BASE]; // RULE_07
    // Index element from the source or destination index.
    index_val = index_sel_in ? regs[SAG_IDX_DEST_INDEX] : regs[SAG_IDX_SOURCE_INDEX]; // RULE_07
    // Byte displacement carries its sign into the upper byte.
    disp_val = disp_wide_in ? disp_in : {{8{disp_in[7]}}, disp_in[7:0]}; // RULE_05 RULE_06
    // A 16-bit sum: any carry out of bit 15 is lost, so the offset wraps.
    ea_val = (elems[2] ? disp_val : 16'h0000)
           + (elems[1] ? base_val : 16'h0000)
           + (elems[0] ? index_val : 16'h0000); // RULE_03 RULE_04 RULE_14 RULE_15
  end

  // Pick the segment: an override wins, else stack segment when the base pointer is an element, else data.
  always_comb
  begin
    base_pointer_used = elems[1] && base_sel_in;
    if (seg_override_in)
    begin
      // An override prefix names the segment explicitly.
      seg_sel = seg_override_sel_in; // RULE_09
    end
    else if (base_pointer_used)
    begin
      seg_sel = SAG_SEG_STACK; // RULE_09
    end
    else
    begin
      seg_sel = SAG_SEG_DATA; // RULE_09
    end
    seg_val = regs[SAG_IDX_SEG_BASE + {2'b00, seg_sel}];
  end

  // Build the next output state.
  always_comb
  begin
    state_next = state_reg;
    state_next.valid = req_valid_in;
    // Instruction fetch address from code segment and instruction pointer.
    state_next.fetch_addr = (SAG_PHYS_W'(regs[SAG_IDX_CODE_SEGMENT]) << SAG_SEG_SHIFT)
                          + SAG_PHYS_W'(regs[SAG_IDX_INSTRUCTION_POINTER]); // RULE_01 RULE_16
    if (req_valid_in)
    begin
      state_next.eff_addr = ea_val; // RULE_02
      state_next.seg_sel = seg_sel;
      // Shift the segment four places and add the offset; carry out of bit 19 is lost.
      state_next.phys_addr = (SAG_PHYS_W'(seg_val) << SAG_SEG_SHIFT)
                           + SAG_PHYS_W'(ea_val); // RULE_01 RULE_16
      state_next.mem_access = 1'b0;
      state_next.operand = 16'h0000;
      unique case (mode)
        SAG_MODE_REGISTER:
        begin
          // Operand comes from a general register.
          state_next.operand = read_operand(regs, rd_idx_in, rd_byte_in); // RULE_12
        end
        SAG_MODE_IMMEDIATE:
        begin
          // Operand is the instruction's immediate; no memory cycle.
          state_next.operand = disp_wide_in ? disp_in : {8'h00, disp_in[7:0]}; // RULE_13
        end
        default:
        begin
          // Any of the six memory modes asks for a memory access.
          state_next.mem_access = 1'b1; // RULE_08
        end
      endcase
    end
  end

  // Register the output state; synchronous reset clears it.
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // Every output comes straight from the output stage flops.
  assign addr_valid_out = state_reg.valid;
  assign mem_access_out = state_reg.mem_access;
  assign eff_addr_out = state_reg.eff_addr;
  assign phys_addr_out = state_reg.phys_addr;
  assign seg_sel_out = state_reg.seg_sel;
  assign operand_out = state_reg.operand;
  assign fetch_addr_out = state_reg.fetch_addr;

endmodule

`default_nettype wire

/* File: verification/sag_chk.sv */
// Port checker for the address generator.
`timescale 1ns/1ps
`default_nettype none

module sag_chk
  import sag_pkg::*;
(
  // Clock, reset and request side.
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic req_valid_in,
  input wire logic [2:0] mode_in,
  input wire logic [15:0] disp_in,
  input wire logic disp_wide_in,
  input wire logic seg_override_in,
  input wire logic [1:0] seg_override_sel_in,
  // Result side.
  input wire logic addr_valid_out,
  input wire logic mem_access_out,
  input wire logic [15:0] eff_addr_out,
  input wire logic [1:0] seg_sel_out,
  input wire logic [15:0] operand_out
);
  // Byte displacement widened by its sign bit.
  logic [15:0] disp_sext;
  assign disp_sext = {{8{disp_in[7]}}, disp_in[7:0]};
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  // A request that reaches memory, and the direct form of it.
  sequence s_mem_req;
    req_valid_in && mode_in >= SAG_MODE_DIRECT;
  endsequence
  sequence s_direct;
    req_valid_in && mode_in == SAG_MODE_DIRECT;
  endsequence
  AST_ANSWER: assert property (req_valid_in |=> addr_valid_out)
    else $error("request not answered");
  AST_NO_SPURIOUS: assert property (!req_valid_in |=> !addr_valid_out)
    else $error("answer without request");
  AST_MEM_FLAG: assert property (s_mem_req |=> mem_access_out)
    else $error("memory mode without access flag");
  AST_NO_MEM: assert property (req_valid_in && mode_in < 3'd2 |=> !mem_access_out)
    else $error("operand mode flagged as memory");
  AST_DIRECT_WORD: assert property (s_direct ##0 disp_wide_in |=>
    eff_addr_out == $past(disp_in)) else $error("direct offset wrong");
  AST_DISP_SEXT: assert property (s_direct ##0 !disp_wide_in |=>
    eff_addr_out == $past(disp_sext)) else $error("byte displacement not widened");
  AST_OVERRIDE: assert property (s_mem_req ##0 seg_override_in |=>
    seg_sel_out == $past(seg_override_sel_in)) else $error("override ignored");
  AST_IMMEDIATE: assert property (req_valid_in && mode_in == 3'd1 && disp_wide_in |=>
    operand_out == $past(disp_in)) else $error("immediate operand wrong");
endmodule

bind sag_addr_gen sag_chk u_chk (.sys_clk_in, .rst_n_in, .req_valid_in, .mode_in, .disp_in,
  .disp_wide_in, .seg_override_in, .seg_override_sel_in, .addr_valid_out, .mem_access_out,
  .eff_addr_out, .seg_sel_out, .operand_out);

`default_nettype wire

/* File: verification/sag_biu_model.sv */
// Bus interface unit model that latches each memory address handed to it.
`timescale 1ns/1ps
`default_nettype none

module sag_biu_model (
  // Clock.
  input wire logic sys_clk_in,
  // Address hand-over from the generator.
  input wire logic addr_valid_in,
  input wire logic mem_access_in,
  input wire logic [19:0] phys_addr_in,
  // Address of the last bus cycle opened.
  output logic [19:0] bus_addr_out
);
  // Only memory requests open a bus cycle; operand modes are ignored.
  always_ff @(posedge sys_clk_in)
  begin
    if (addr_valid_in && mem_access_in)
    begin
      bus_addr_out <= phys_addr_in;
    end
  end
endmodule

`default_nettype wire

/* File: verification/tb_top.sv */
// Self-checking bench for the address generator.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import sag_pkg::*;
  logic sys_clk_in, rst_n_in, req_valid_in, base_sel_in, index_sel_in, ind_base_in;
  logic disp_wide_in, seg_override_in, rd_byte_in, wr_en_in, wr_byte_in;
  logic addr_valid_out, mem_access_out;
  logic [2:0] mode_in;
  logic [1:0] seg_override_sel_in, seg_sel_out;
  logic [3:0] rd_idx_in, wr_idx_in;
  logic [15:0] disp_in, wr_data_in, eff_addr_out, operand_out;
  logic [19:0] phys_addr_out, fetch_addr_out, bus_addr;
  logic [15:0] rm [SAG_NUM_REGS];
  int errors, n_compared;

  sag_addr_gen DUT (.sys_clk_in, .rst_n_in, .req_valid_in, .mode_in, .base_sel_in,
    .index_sel_in, .ind_base_in, .disp_in, .disp_wide_in, .seg_override_in,
    .seg_override_sel_in, .rd_idx_in, .rd_byte_in, .wr_en_in, .wr_idx_in, .wr_byte_in,
    .wr_data_in, .addr_valid_out, .mem_access_out, .eff_addr_out, .phys_addr_out,
    .seg_sel_out, .operand_out, .fetch_addr_out);
  sag_biu_model u_biu (.sys_clk_in, .addr_valid_in(addr_valid_out),
    .mem_access_in(mem_access_out), .phys_addr_in(phys_addr_out), .bus_addr_out(bus_addr));

  initial
  begin
    sys_clk_in = 1'b0;
    forever #10 sys_clk_in = ~sys_clk_in;
  end

  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    if (errors == 0 && n_compared > 0)
    begin
      $display("RESULT: PASS");
    end
    else
    begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Writes one slot and mirrors it; byte codes pick a half of the first four words.
  task automatic wr(input logic [3:0] i, input logic b, input logic [15:0] d);
    @(negedge sys_clk_in);
    wr_en_in = 1'b1;
    wr_idx_in = i;
    wr_byte_in = b;
    wr_data_in = d;
    if (!b)
      rm[i] = d;
    else if (i[2])
      rm[i[1:0]][15:8] = d[7:0];
    else
      rm[i[1:0]][7:0] = d[7:0];
    @(negedge sys_clk_in);
    wr_en_in = 1'b0;
  endtask

  // Issues one memory request and checks offset, segment and address.
  task automatic req(input logic [2:0] m, input logic bs, input logic xs, input logic ib,
    input logic [15:0] d, input logic w, input logic ov, input logic [1:0] os);
    logic [15:0] dsp, b, x, e;
    logic [1:0] sg;
    logic [19:0] p;
    dsp = w ? d : {{8{d[7]}}, d[7:0]};
    b = bs ? rm[SAG_IDX_BASE_POINTER] : rm[SAG_IDX_BASE];
    x = xs ? rm[SAG_IDX_DEST_INDEX] : rm[SAG_IDX_SOURCE_INDEX];
    case (m)
      3'd2: e = dsp;
      3'd3: e = ib ? b : x;
      3'd4: e = b + dsp;
      3'd5: e = x + dsp;
      3'd6: e = b + x;
      default: e = b + x + dsp;
    endcase
    sg = (bs && (m == 3'd4 || m >= 3'd6 || (m == 3'd3 && ib))) ? SAG_SEG_STACK : SAG_SEG_DATA;
    sg = ov ? os : sg;
    p = {rm[SAG_IDX_SEG_BASE + 4'(sg)], 4'h0} + e;
    @(negedge sys_clk_in);
    {mode_in, base_sel_in, index_sel_in, ind_base_in} = {m, bs, xs, ib};
    {disp_in, disp_wide_in, seg_override_in, seg_override_sel_in} = {d, w, ov, os};
    req_valid_in = 1'b1;
    @(negedge sys_clk_in);
    req_valid_in = 1'b0;
    chk(addr_valid_out & mem_access_out, 1'b1);
    chk(eff_addr_out, e);
    chk(seg_sel_out, sg);
    chk(phys_addr_out, p);
    @(negedge sys_clk_in);
    chk(bus_addr, p);
    chk(addr_valid_out, 1'b0);
  endtask

  // Issues a register or immediate request and checks the operand.
  task automatic opr(input logic [2:0] m, input logic [3:0] ri, input logic rb,
    input logic [15:0] d, input logic w, input logic [15:0] exp);
    @(negedge sys_clk_in);
    {mode_in, rd_idx_in, rd_byte_in, disp_in, disp_wide_in} = {m, ri, rb, d, w};
    req_valid_in = 1'b1;
    @(negedge sys_clk_in);
    req_valid_in = 1'b0;
    chk(operand_out, exp);
    chk(mem_access_out, 1'b0);
  endtask

  // Operand and offset outputs are clear after reset; fetch address wraps.
  task automatic t_fetch();
    chk(operand_out | eff_addr_out, 16'h0000);
    wr(SAG_IDX_CODE_SEGMENT, 1'b0, 16'hffff);
    wr(SAG_IDX_INSTRUCTION_POINTER, 1'b0, 16'h0020);
    @(negedge sys_clk_in);
    chk(fetch_addr_out, 20'h00010);
  endtask

  // All memory modes, both bases, both indexes, byte and word displacements.
  // Register indirect sees both base registers and both index registers.
  task automatic t_modes();
    wr(SAG_IDX_BASE, 1'b0, 16'h1234);
    wr(SAG_IDX_BASE_POINTER, 1'b0, 16'h8000);
    wr(SAG_IDX_SOURCE_INDEX, 1'b0, 16'h0011);
    wr(SAG_IDX_DEST_INDEX, 1'b0, 16'hf000);
    wr(SAG_IDX_DATA_SEGMENT, 1'b0, 16'h1000);
    wr(SAG_IDX_STACK_SEGMENT, 1'b0, 16'h2000);
    wr(SAG_IDX_EXTRA_SEGMENT, 1'b0, 16'h3000);
    for (int m = 2; m < 8; m++)
      for (int k = 0; k < 8; k++)
        req(3'(m), k[0], k[1], k[0] ^ k[1], k[2] ? 16'hfff0 : 16'h0080, k[2], 1'b0, 2'b00);
  endtask

  // Every override code wins over the implied stack segment.
  task automatic t_override();
    for (int s = 0; s < 4; s++)
      req(3'd7, 1'b1, 1'b1, 1'b0, 16'h0004, 1'b1, 1'b1, 2'(s));
  endtask

  // Byte halves of the accumulator and count, then immediate forms.
  task automatic t_operands();
    wr(SAG_IDX_ACCUMULATOR, 1'b0, 16'h1234);
    wr(4'h4, 1'b1, 16'h00ab);
    wr(4'h1, 1'b1, 16'h00cd);
    opr(3'd0, 4'h0, 1'b0, 16'h0000, 1'b0, 16'hab34);
    opr(3'd0, 4'h4, 1'b1, 16'h0000, 1'b0, 16'h00ab);
    opr(3'd0, 4'h1, 1'b1, 16'h0000, 1'b0, 16'h00cd);
    opr(3'd1, 4'h0, 1'b0, 16'hbeef, 1'b1, 16'hbeef);
    opr(3'd1, 4'h0, 1'b0, 16'h12c5, 1'b0, 16'h00c5);
  endtask

  // A hang is cut short and counted as a mismatch.
  initial
  begin
    repeat (100000) @(posedge sys_clk_in);
    errors++;
    test_done();
  end

  initial
  begin
    {rst_n_in, req_valid_in, base_sel_in, index_sel_in, ind_base_in, disp_wide_in} = '0;
    {seg_override_in, rd_byte_in, wr_en_in, wr_byte_in, mode_in, seg_override_sel_in} = '0;
    {rd_idx_in, wr_idx_in, disp_in, wr_data_in} = '0;
    for (int i = 0; i < SAG_NUM_REGS; i++)
      rm[i] = SAG_REG_RESET;
    repeat (8) @(negedge sys_clk_in);
    rst_n_in = 1'b1;
    t_fetch();
    t_modes();
    t_override();
    t_operands();
    test_done();
  end
endmodule

`default_nettype wire
